// [mrp_consts.svh]
`ifndef MRP_CONSTS_SVH
`define MRP_CONSTS_SVH

// Register word offsets on the plain register port.
`define MRP_REG_CTRL 4'h0
`define MRP_REG_LOW_THR 4'h1
`define MRP_REG_HOLD_THR 4'h2
`define MRP_REG_HIGH_THR 4'h3
`define MRP_REG_BP_AB 4'h4
`define MRP_REG_BP_CD 4'h5
`define MRP_REG_BP_E_HYS 4'h6
`define MRP_REG_REF_AB 4'h7
`define MRP_REG_REF_CD 4'h8
`define MRP_REG_REF_E_LH 4'h9
`define MRP_REG_REF_HH_HO 4'hA
`define MRP_REG_REF_LO_FLOOR 4'hB
`define MRP_REG_FS_SPEED 4'hC
`define MRP_REG_FS_POWER 4'hD
`define MRP_REG_STATUS 4'hE
`define MRP_REG_LAST 4'hD

// Field positions inside the registers.
`define MRP_LO_BYTE 7:0
`define MRP_HI_BYTE 15:8
`define MRP_CTRL_PROF 1:0
`define MRP_CTRL_CLOSED_BIT 2
`define MRP_CTRL_CPOWER_BIT 3
`define MRP_CTRL_DIR_BIT 4

// Reset values.
`define MRP_CFG_RST 16'h0000
`define MRP_DATA_RST 16'h0000
`define MRP_REF_RST 8'h00

// Full scale of a profiler output and of the duty command.
`define MRP_SCALE_DIV 24'h0000FF

`endif

// [mrp_pkg.sv]
package mrp_pkg;

	// Profile selection, in the order of its two-bit code.
	typedef enum logic [1:0] {
		MRP_PROF_BYPASS,
		MRP_PROF_LINEAR,
		MRP_PROF_STAIR,
		MRP_PROF_FWDREV
	} mrp_prof_e;

	// Forward-reverse zone state.
	typedef enum logic [1:0] {
		MRP_ZONE_FWD,
		MRP_ZONE_OFF,
		MRP_ZONE_REV
	} mrp_zone_e;

	// Kind of reference handed to the control stage.
	typedef enum logic [1:0] {
		MRP_KIND_VOLT,
		MRP_KIND_SPEED,
		MRP_KIND_POWER
	} mrp_kind_e;

	typedef logic [7:0] mrp_duty_t;
	typedef logic [2:0] mrp_step_t;

endpackage

// [mrp_lerp.sv]
`timescale 1ns/1ps
module mrp_lerp (
	// Clock, reset and freeze.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Segment and position.
	input wire logic in_valid,
	input wire logic [7:0] x,
	input wire logic [7:0] x0,
	input wire logic [7:0] x1,
	input wire logic [7:0] y0,
	input wire logic [7:0] y1,
	// Registered result.
	output logic [7:0] y,
	output logic out_valid
);
	logic [7:0] span;
	logic signed [9:0] dx;
	logic signed [8:0] dy;
	logic signed [18:0] prod;
	logic signed [18:0] quo;
	logic signed [9:0] sum;
	logic [7:0] next_y;

	// Straight line through both end points; a zero span gives the far end.
	always_comb begin
		span = x1 - x0;
		dx = $signed({2'b00, 8'(x - x0)});
		dy = $signed({1'b0, y1}) - $signed({1'b0, y0});
		prod = dy * dx;
		quo = 19'sh00000;
		if (span != 8'h00) begin
			quo = prod / $signed({11'h000, span});
		end
		sum = $signed({2'b00, y0}) + $signed(quo[9:0]);
		next_y = (span == 8'h00) ? y1 : sum[7:0];
	end

	// Result register, one cycle after the segment is presented.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			y <= 8'h00;
			out_valid <= 1'b0;
		end else if (ce) begin
			out_valid <= in_valid;
			if (in_valid) begin
				y <= next_y;
			end
		end
	end

	// A position between the end points never gives a value outside their range.
	property p_lerp_range;
		@(posedge clk) disable iff (!rst_n)
		(ce && in_valid && x >= x0 && x <= x1) |=>
		((y >= $past(y0) && y <= $past(y1)) ||
		(y <= $past(y0) && y >= $past(y1)));
	endproperty
	a_lerp_range: assert property (p_lerp_range)
		else $error("interpolated value outside its segment");

endmodule

// [mrp_profiler.sv]
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - A zero duty command always stops the motor, in every profile.
// - Profile code 01b selects the linear piecewise profile.
// - Below low cutoff the off reference applies; restart uses hysteresis.
// - Linear: hold low reference, then interpolate through breakpoints a to e.
// - Linear: interpolate from e to high hold threshold, then hold.
// - Above high cutoff the high off reference applies, with hysteresis.
// - Profile code 10b selects the staircase profile.
// - Staircase steps at low hold threshold and at breakpoints a to e.
// - Every staircase step uses the step hysteresis width.
// - Profile code 11b selects forward-reverse; duty sets direction.
// - Forward-reverse: direction flips where duty crosses breakpoint c.
// - Forward-reverse ignores the direction pin and the direction bit.
// - Forward-reverse: ramp to a, hold a to b, motor off above b.
// - Forward-reverse: reverse above d, hold d, ramp e to high hold.
// - Forward-reverse: above high cutoff the reverse reference turns off.
// - Forward-reverse transitions at b and d use step hysteresis.
// - Reference kind follows the closed loop and constant power bits.
// - Bypass speed: full duty gives full-scale speed, floor sets minimum.
// - Zero full-scale speed forces zero speed and a stopped motor.
// - Bypass power: full duty gives full-scale power, floor sets minimum.
// - Zero full-scale power forces zero power and a stopped motor.
// - Bypass voltage: duty tracks the command from floor up, zero below it.
// - Profile code 00b passes the duty command straight through.
// - A profiler output is a fraction of 255 of the full scale.
`include "mrp_consts.svh"
module mrp_profiler (
	// Clock, reset and freeze.
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic CE,
	// Register port.
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// Duty command source.
	input wire mrp_pkg::mrp_duty_t DUTY_CMD,
	input wire logic DUTY_VALID,
	input wire logic DIR_IN,
	// Reference to the control stage.
	output mrp_pkg::mrp_duty_t REF_OUT,
	output logic [15:0] SPEED_REF,
	output logic [15:0] POWER_REF,
	output mrp_pkg::mrp_duty_t VOLT_DUTY,
	output mrp_pkg::mrp_kind_e REF_KIND,
	output logic MOTOR_STOP,
	output logic DIR_REV,
	output logic REF_VALID
);
	import mrp_pkg::*;

	logic [15:0] cfg [0:13];
	mrp_prof_e prof;
	logic closed_loop, const_power, dir_bit;
	mrp_duty_t low_cut, low_restart, lh_thr, hh_thr, high_cut, high_restart;
	mrp_duty_t bp_a, bp_b, bp_c, bp_d, bp_e, hys;
	mrp_duty_t ref_a, ref_b, ref_c, ref_d, ref_e;
	mrp_duty_t lh_ref, hh_ref, ho_ref, lo_ref, floor_frac;
	logic [15:0] fs_speed, fs_power;
	logic [6:0][7:0] knot_x, knot_y, fr_thr;
	mrp_duty_t duty_s1, duty_s2;
	logic smp_v, bypass_s2, stop_s2;
	logic low_off, high_off, next_low_off, next_high_off;
	mrp_step_t step, next_step, cnt_up, cnt_dn, lin_k;
	mrp_zone_e zone, next_zone;
	logic [2:0] zup, zdn;
	mrp_duty_t sx0, sx1, sy0, sy1;
	logic next_stop, next_dir;
	mrp_duty_t lerp_y;
	logic lerp_v;
	mrp_kind_e kind;
	mrp_duty_t eff;
	logic [23:0] spd_prod, pwr_prod, spd_scaled, pwr_scaled;

	// Counts the first n thresholds reached by duty plus a margin.
	function automatic mrp_step_t count_past(input mrp_duty_t d,
			input logic [6:0][7:0] thr, input logic [2:0] n,
			input mrp_duty_t margin);
		mrp_step_t cnt;
		cnt = 3'd0;
		for (int i = 0; i < 7; i++) begin
			if (3'(i) < n &&
					({1'b0, d} + {1'b0, margin}) >= {1'b0, thr[i]}) begin
				cnt = cnt + 3'd1;
			end
		end
		return cnt;
	endfunction

	// Configuration fields.
	assign prof = mrp_prof_e'(cfg[`MRP_REG_CTRL][`MRP_CTRL_PROF]);
	assign closed_loop = cfg[`MRP_REG_CTRL][`MRP_CTRL_CLOSED_BIT];
	assign const_power = cfg[`MRP_REG_CTRL][`MRP_CTRL_CPOWER_BIT];
	assign dir_bit = cfg[`MRP_REG_CTRL][`MRP_CTRL_DIR_BIT];
	assign low_cut = cfg[`MRP_REG_LOW_THR][`MRP_LO_BYTE];
	assign low_restart = cfg[`MRP_REG_LOW_THR][`MRP_HI_BYTE];
	assign lh_thr = cfg[`MRP_REG_HOLD_THR][`MRP_LO_BYTE];
	assign hh_thr = cfg[`MRP_REG_HOLD_THR][`MRP_HI_BYTE];
	assign high_cut = cfg[`MRP_REG_HIGH_THR][`MRP_LO_BYTE];
	assign high_restart = cfg[`MRP_REG_HIGH_THR][`MRP_HI_BYTE];
	assign bp_a = cfg[`MRP_REG_BP_AB][`MRP_LO_BYTE];
	assign bp_b = cfg[`MRP_REG_BP_AB][`MRP_HI_BYTE];
	assign bp_c = cfg[`MRP_REG_BP_CD][`MRP_LO_BYTE];
	assign bp_d = cfg[`MRP_REG_BP_CD][`MRP_HI_BYTE];
	assign bp_e = cfg[`MRP_REG_BP_E_HYS][`MRP_LO_BYTE];
	assign hys = cfg[`MRP_REG_BP_E_HYS][`MRP_HI_BYTE];
	assign ref_a = cfg[`MRP_REG_REF_AB][`MRP_LO_BYTE];
	assign ref_b = cfg[`MRP_REG_REF_AB][`MRP_HI_BYTE];
	assign ref_c = cfg[`MRP_REG_REF_CD][`MRP_LO_BYTE];
	assign ref_d = cfg[`MRP_REG_REF_CD][`MRP_HI_BYTE];
	assign ref_e = cfg[`MRP_REG_REF_E_LH][`MRP_LO_BYTE];
	assign lh_ref = cfg[`MRP_REG_REF_E_LH][`MRP_HI_BYTE];
	assign hh_ref = cfg[`MRP_REG_REF_HH_HO][`MRP_LO_BYTE];
	assign ho_ref = cfg[`MRP_REG_REF_HH_HO][`MRP_HI_BYTE];
	assign lo_ref = cfg[`MRP_REG_REF_LO_FLOOR][`MRP_LO_BYTE];
	assign floor_frac = cfg[`MRP_REG_REF_LO_FLOOR][`MRP_HI_BYTE];
	assign fs_speed = cfg[`MRP_REG_FS_SPEED];
	assign fs_power = cfg[`MRP_REG_FS_POWER];

	// Knots of the profile curve; the order relies on ascending programming.
	assign knot_x = {hh_thr, bp_e, bp_d, bp_c, bp_b, bp_a, lh_thr};
	assign knot_y = {hh_ref, ref_e, ref_d, ref_c, ref_b, ref_a, lh_ref};
	assign fr_thr = {40'h0000000000, bp_d, bp_b};

	// Configuration writes; the status word is read only.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int i = 0; i < 14; i++) begin
				cfg[i] <= `MRP_CFG_RST;
			end
		end else if (CE && WR && ADDR <= `MRP_REG_LAST) begin
			cfg[ADDR] <= WDATA;
		end
	end

	// Read data stands in the cycle after the read strobe only.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			RDATA <= `MRP_DATA_RST;
		end else if (CE) begin
			RDATA <= `MRP_DATA_RST;
			if (RD && ADDR <= `MRP_REG_LAST) begin
				RDATA <= cfg[ADDR];
			end else if (RD && ADDR == `MRP_REG_STATUS) begin
				RDATA <= {REF_OUT, DIR_REV, high_off, low_off, zone, step};
			end
		end
	end

	// Duty command sample.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			duty_s1 <= `MRP_REF_RST;
			smp_v <= 1'b0;
		end else if (CE) begin
			smp_v <= DUTY_VALID;
			if (DUTY_VALID) begin
				duty_s1 <= DUTY_CMD;
			end
		end
	end

	// Band counts for the staircase and forward-reverse state and the linear segment.
	always_comb begin
		cnt_up = count_past(duty_s1, knot_x, 3'd6, 8'h00);
		cnt_dn = count_past(duty_s1, knot_x, 3'd6, hys);
		zup = count_past(duty_s1, fr_thr, 3'd2, 8'h00);
		zdn = count_past(duty_s1, fr_thr, 3'd2, hys);
		lin_k = count_past(duty_s1, knot_x, 3'd7, 8'h00);
	end

	// Hysteresis state and segment choice for the current sample.
	always_comb begin
		next_low_off = low_off;
		next_high_off = high_off;
		next_step = step;
		next_zone = zone;
		sx0 = 8'h00;
		sx1 = 8'h00;
		sy0 = duty_s1;
		sy1 = duty_s1;
		next_stop = (duty_s1 == 8'h00);
		next_dir = DIR_IN ^ dir_bit;
		if (low_off) begin
			if (duty_s1 >= low_restart) next_low_off = 1'b0;
		end else if (duty_s1 < low_cut) begin
			next_low_off = 1'b1;
		end
		if (high_off) begin
			if (duty_s1 < high_restart) next_high_off = 1'b0;
		end else if (duty_s1 > high_cut) begin
			next_high_off = 1'b1;
		end
		// Move only when the duty leaves the band on the far side.
		if (cnt_up > step) begin
			next_step = cnt_up;
		end else if (cnt_dn < step) begin
			next_step = cnt_dn;
		end
		if (zup > 3'(zone)) begin
			next_zone = mrp_zone_e'(zup[1:0]);
		end else if (zdn < 3'(zone)) begin
			next_zone = mrp_zone_e'(zdn[1:0]);
		end
		unique case (prof)
			MRP_PROF_BYPASS: begin
				sy0 = duty_s1;
			end
			MRP_PROF_LINEAR: begin
				// Hold below the first knot and above the last.
				if (lin_k == 3'd0) begin
					sy0 = lh_ref;
					sy1 = lh_ref;
				end else if (lin_k == 3'd7) begin
					sy0 = hh_ref;
					sy1 = hh_ref;
				end else begin
					sx0 = knot_x[lin_k - 3'd1];
					sx1 = knot_x[lin_k];
					sy0 = knot_y[lin_k - 3'd1];
					sy1 = knot_y[lin_k];
				end
			end
			MRP_PROF_STAIR: begin
				sy0 = knot_y[next_step];
				sy1 = knot_y[next_step];
			end
			MRP_PROF_FWDREV: begin
				next_dir = (next_zone == MRP_ZONE_REV) ||
					(next_zone == MRP_ZONE_OFF && duty_s1 >= bp_c);
				unique case (next_zone)
					MRP_ZONE_FWD: begin
						if (duty_s1 < lh_thr) begin
							sy0 = lh_ref;
							sy1 = lh_ref;
						end else if (duty_s1 < bp_a) begin
							sx0 = lh_thr;
							sx1 = bp_a;
							sy0 = lh_ref;
							sy1 = ref_a;
						end else begin
							sy0 = ref_a;
							sy1 = ref_a;
						end
					end
					MRP_ZONE_OFF: begin
						sy0 = 8'h00;
						sy1 = 8'h00;
						next_stop = 1'b1;
					end
					MRP_ZONE_REV: begin
						if (duty_s1 < bp_e) begin
							sy0 = ref_d;
							sy1 = ref_d;
						end else if (duty_s1 < hh_thr) begin
							sx0 = bp_e;
							sx1 = hh_thr;
							sy0 = ref_d;
							sy1 = hh_ref;
						end else begin
							sy0 = hh_ref;
							sy1 = hh_ref;
						end
					end
					default: begin
						// The fourth zone code never occurs; stop if it does.
						next_stop = 1'b1;
					end
				endcase
			end
		endcase
		// Cutoff regions override every profile except bypass.
		if (prof != MRP_PROF_BYPASS && next_low_off) begin
			sx0 = 8'h00;
			sx1 = 8'h00;
			sy0 = lo_ref;
			sy1 = lo_ref;
		end else if (prof != MRP_PROF_BYPASS && next_high_off) begin
			sx0 = 8'h00;
			sx1 = 8'h00;
			sy0 = ho_ref;
			sy1 = ho_ref;
		end
	end

	// Hysteresis state advances once per sample.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			low_off <= 1'b1;
			high_off <= 1'b0;
			step <= 3'd0;
			zone <= MRP_ZONE_FWD;
		end else if (CE && smp_v) begin
			low_off <= next_low_off;
			high_off <= next_high_off;
			step <= next_step;
			zone <= next_zone;
		end
	end

	// Side information travelling beside the interpolator.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			duty_s2 <= `MRP_REF_RST;
			bypass_s2 <= 1'b1;
			stop_s2 <= 1'b1;
		end else if (CE && smp_v) begin
			duty_s2 <= duty_s1;
			bypass_s2 <= (prof == MRP_PROF_BYPASS);
			stop_s2 <= next_stop;
		end
	end

	// Interpolation stage.
	mrp_lerp u_lerp (
		.clk(MCLK),
		.rst_n(RST_N),
		.ce(CE),
		.in_valid(smp_v),
		.x(duty_s1),
		.x0(sx0),
		.x1(sx1),
		.y0(sy0),
		.y1(sy1),
		.y(lerp_y),
		.out_valid(lerp_v)
	);

	// Direction is registered with the sample so it leaves with the reference.
	logic dir_s2;
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			dir_s2 <= 1'b0;
		end else if (CE && smp_v) begin
			dir_s2 <= next_dir;
		end
	end

	// Kind selection and scaling to the full-scale values.
	always_comb begin
		kind = MRP_KIND_VOLT;
		if (closed_loop) begin
			kind = const_power ? MRP_KIND_POWER : MRP_KIND_SPEED;
		end
		eff = lerp_y;
		if (bypass_s2 && duty_s2 < floor_frac) begin
			eff = floor_frac;
		end
		spd_prod = eff * fs_speed;
		pwr_prod = eff * fs_power;
		spd_scaled = spd_prod / `MRP_SCALE_DIV;
		pwr_scaled = pwr_prod / `MRP_SCALE_DIV;
	end

	// Output registers.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			REF_OUT <= `MRP_REF_RST;
			SPEED_REF <= `MRP_DATA_RST;
			POWER_REF <= `MRP_DATA_RST;
			VOLT_DUTY <= `MRP_REF_RST;
			REF_KIND <= MRP_KIND_VOLT;
			MOTOR_STOP <= 1'b1;
			DIR_REV <= 1'b0;
			REF_VALID <= 1'b0;
		end else if (CE) begin
			REF_VALID <= lerp_v;
			if (lerp_v) begin
				REF_OUT <= lerp_y;
				REF_KIND <= kind;
				DIR_REV <= dir_s2;
				SPEED_REF <= (kind == MRP_KIND_SPEED) ?
					spd_scaled[15:0] : 16'h0000;
				POWER_REF <= (kind == MRP_KIND_POWER) ?
					pwr_scaled[15:0] : 16'h0000;
				VOLT_DUTY <= (kind != MRP_KIND_VOLT ||
					(bypass_s2 && duty_s2 < floor_frac)) ?
					8'h00 : lerp_y;
				MOTOR_STOP <= stop_s2 ||
					(kind == MRP_KIND_SPEED && fs_speed == 16'h0000) ||
					(kind == MRP_KIND_POWER && fs_power == 16'h0000);
			end
		end
	end

	property p_zero_stop;
		@(posedge MCLK) disable iff (!RST_N)
		(DUTY_VALID && CE && DUTY_CMD == 8'h00) ##1 CE ##1 CE |=>
		MOTOR_STOP && REF_VALID;
	endproperty
	a_zero_stop: assert property (p_zero_stop)
		else $error("zero duty command did not stop the motor");

	property p_latency;
		@(posedge MCLK) disable iff (!RST_N)
		(DUTY_VALID && CE) ##1 CE ##1 CE |=> REF_VALID;
	endproperty
	a_latency: assert property (p_latency)
		else $error("reference not produced two cycles after a sample");

	property p_speed_zero;
		@(posedge MCLK) disable iff (!RST_N)
		(REF_VALID && REF_KIND == MRP_KIND_SPEED &&
		$past(fs_speed) == 16'h0000) |->
		(SPEED_REF == 16'h0000 && MOTOR_STOP);
	endproperty
	a_speed_zero: assert property (p_speed_zero)
		else $error("zero full-scale speed did not force a stop");

	property p_power_zero;
		@(posedge MCLK) disable iff (!RST_N)
		(REF_VALID && REF_KIND == MRP_KIND_POWER &&
		$past(fs_power) == 16'h0000) |->
		(POWER_REF == 16'h0000 && MOTOR_STOP);
	endproperty
	a_power_zero: assert property (p_power_zero)
		else $error("zero full-scale power did not force a stop");

	property p_volt_floor;
		@(posedge MCLK) disable iff (!RST_N)
		(CE && lerp_v && kind == MRP_KIND_VOLT && bypass_s2 &&
		duty_s2 < floor_frac) |=> (VOLT_DUTY == 8'h00);
	endproperty
	a_volt_floor: assert property (p_volt_floor)
		else $error("applied duty not zero below the floor");

	property p_bypass;
		@(posedge MCLK) disable iff (!RST_N)
		(DUTY_VALID && CE && prof == MRP_PROF_BYPASS) ##1
		(CE && prof == MRP_PROF_BYPASS) ##1 CE |=>
		REF_OUT == $past(DUTY_CMD, 3);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass reference differs from the duty command");

	property p_fwd_dir;
		@(posedge MCLK) disable iff (!RST_N)
		(CE && smp_v && prof == MRP_PROF_FWDREV &&
		next_zone == MRP_ZONE_FWD) ##1 CE |=> !DIR_REV;
	endproperty
	a_fwd_dir: assert property (p_fwd_dir)
		else $error("forward zone reported reverse direction");

	property p_low_off;
		@(posedge MCLK) disable iff (!RST_N)
		(CE && smp_v && prof != MRP_PROF_BYPASS && duty_s1 < low_cut &&
		$stable(lo_ref)) ##1 (CE && $stable(lo_ref)) |=>
		REF_OUT == $past(lo_ref);
	endproperty
	a_low_off: assert property (p_low_off)
		else $error("low off reference not applied below cutoff");

	property p_step_hold;
		@(posedge MCLK) disable iff (!RST_N)
		(CE && smp_v && prof == MRP_PROF_STAIR && cnt_up <= step &&
		cnt_dn >= step) |=> $stable(step);
	endproperty
	a_step_hold: assert property (p_step_hold)
		else $error("staircase step moved inside its band");

endmodule

// [mrp_duty_src.sv]
`timescale 1ns/1ps
module mrp_duty_src (
	// Clock.
	input wire logic clk,
	// Request from the bench.
	input wire logic go,
	input wire mrp_pkg::mrp_duty_t val,
	// Sample stream towards the profiler.
	output mrp_pkg::mrp_duty_t duty_cmd,
	output logic duty_valid
);
	import mrp_pkg::*;

	// Registers one sample per request; between samples the value toggles.
	initial begin
		duty_cmd = 8'h00;
		duty_valid = 1'b0;
	end

	// An idle command bus never shows a stale value that could be taken.
	always @(posedge clk) begin
		duty_valid <= go;
		duty_cmd <= go ? val : ~duty_cmd;
	end
endmodule

// [motor_reference_profiler_tb_top.sv]
`timescale 1ns/1ps
`include "mrp_consts.svh"
module motor_reference_profiler_tb_top;
	import mrp_pkg::*;

	typedef struct {
		logic [15:0] v;
		logic [2:0] sel;
		logic [1:0] stop;
		logic [1:0] rev;
		mrp_kind_e kind;
		int stamp;
	} mrp_note_s;

	logic MCLK = 1'b0;
	logic RST_N = 1'b0;
	logic [3:0] ADDR = 4'h0;
	logic [15:0] WDATA = 16'h0000;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic DIR_IN = 1'b0;
	logic CE = 1'b1;
	logic go = 1'b0;
	mrp_duty_t val = 8'h00;
	mrp_duty_t DUTY_CMD, VOLT_DUTY, REF_OUT;
	logic DUTY_VALID, MOTOR_STOP, DIR_REV, REF_VALID;
	logic [15:0] RDATA, SPEED_REF, POWER_REF;
	mrp_kind_e REF_KIND;
	mrp_kind_e ekind = MRP_KIND_SPEED;
	mrp_note_s q[$];
	logic [15:0] cfg [1:13];
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int e;

	// The clock and a free cycle count for latency checks.
	always #10 MCLK = ~MCLK;
	always @(posedge MCLK) cyc <= cyc + 1;

	mrp_duty_src mrp_duty_src_i (.clk(MCLK), .go(go), .val(val),
		.duty_cmd(DUTY_CMD), .duty_valid(DUTY_VALID));

	mrp_profiler mrp_profiler_i (.MCLK(MCLK), .RST_N(RST_N), .CE(CE),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.DUTY_CMD(DUTY_CMD), .DUTY_VALID(DUTY_VALID), .DIR_IN(DIR_IN),
		.REF_OUT(REF_OUT), .SPEED_REF(SPEED_REF), .POWER_REF(POWER_REF),
		.VOLT_DUTY(VOLT_DUTY), .REF_KIND(REF_KIND),
		.MOTOR_STOP(MOTOR_STOP), .DIR_REV(DIR_REV), .REF_VALID(REF_VALID));

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input string name, input logic [15:0] exp,
			input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One-cycle register write.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge MCLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask

	// One-cycle register read; data is taken in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge MCLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge MCLK);
		RD <= 1'b0;
		@(posedge MCLK);
		chk("RDATA", exp, RDATA);
	endtask

	// Sends one sample and notes the result expected for it.
	// Selector 0 reference, 1 speed, 2 power, 3 voltage, 7 none; 2 skips.
	task automatic s(input mrp_duty_t d, input logic [15:0] v,
			input logic [2:0] sel, input logic [1:0] stop,
			input logic [1:0] rev);
		mrp_note_s n;
		@(posedge MCLK);
		n = '{v, sel, stop, rev, ekind, cyc};
		q.push_back(n);
		go <= 1'b1;
		val <= d;
	endtask

	// Ends a burst and waits, bounded, until every note is answered.
	task automatic flush();
		int i;
		@(posedge MCLK);
		go <= 1'b0;
		for (i = 0; i < 20 && q.size() > 0; i++) @(posedge MCLK);
		if (q.size() > 0) begin
			$display("unexpected REF_VALID expected %0d seen 0", q.size());
			mismatches++;
			results();
		end
	endtask

	// Takes the oldest note whenever a result appears and compares.
	always @(posedge MCLK) begin
		mrp_note_s n;
		logic [15:0] got;
		if (REF_VALID === 1'b1) begin
			if (q.size() == 0) begin
				chk("REF_VALID", 16'h0000, 16'h0001);
			end else begin
				n = q.pop_front();
				chk("latency", 16'h0005, 16'(cyc - n.stamp));
				chk("REF_KIND", 16'(n.kind), 16'(REF_KIND));
				case (n.sel)
					3'h0: got = {8'h00, REF_OUT};
					3'h1: got = SPEED_REF;
					3'h2: got = POWER_REF;
					3'h3: got = {8'h00, VOLT_DUTY};
					default: got = n.v;
				endcase
				chk("reference", n.v, got);
				if (n.stop != 2'h2) begin
					chk("MOTOR_STOP", 16'(n.stop), 16'(MOTOR_STOP));
				end
				if (n.rev != 2'h2) begin
					chk("DIR_REV", 16'(n.rev), 16'(DIR_REV));
				end
			end
		end
	end

	// A hang anywhere counts as a mismatch.
	initial begin
		repeat (50000) @(posedge MCLK);
		mismatches++;
		results();
	end

	// Main sequence.
	initial begin
		cfg = '{16'h140A, 16'hBE1E, 16'hD2DC, 16'h3C28, 16'h6450, 16'h0578,
			16'h4632, 16'h6E5A, 16'h1E82, 16'h05C8, 16'h2803, 16'h03E8,
			16'h01F4};
		void'($urandom(55389));
		repeat (5) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		chk("MOTOR_STOP", 16'h0001, 16'(MOTOR_STOP));
		chk("REF_OUT", 16'h0000, 16'(REF_OUT));
		rd(`MRP_REG_CTRL, 16'h0000);
		rd(`MRP_REG_STATUS, 16'h0020);
		wr(`MRP_REG_STATUS, 16'hFFFF);
		rd(`MRP_REG_STATUS, 16'h0020);
		rd(4'hF, 16'h0000);
		for (int a = 1; a <= 13; a++) begin
			wr(4'(a), cfg[a]);
			rd(4'(a), cfg[a]);
		end
		// A frozen block ignores a write on the register port.
		CE <= 1'b0;
		wr(`MRP_REG_REF_LO_FLOOR, 16'hFFFF);
		CE <= 1'b1;
		rd(`MRP_REG_REF_LO_FLOOR, 16'h2803);
		// Linear profile, cutoffs and their hysteresis.
		wr(`MRP_REG_CTRL, 16'h0005);
		s(15, 3, 0, 2, 2);
		s(25, 30, 0, 0, 2);
		s(15, 30, 0, 0, 2);
		s(35, 40, 0, 0, 0);
		s(50, 60, 0, 0, 0);
		s(155, 165, 0, 0, 0);
		s(200, 200, 0, 0, 0);
		s(230, 5, 0, 2, 2);
		s(215, 5, 0, 2, 2);
		s(205, 200, 0, 0, 0);
		s(5, 3, 0, 2, 2);
		s(0, 3, 0, 1, 2);
		flush();
		// Staircase profile with step hysteresis.
		wr(`MRP_REG_CTRL, 16'h0006);
		s(25, 30, 0, 0, 2);
		s(30, 50, 0, 0, 2);
		s(42, 70, 0, 0, 2);
		s(38, 70, 0, 0, 2);
		s(34, 50, 0, 0, 2);
		s(45, 70, 0, 0, 2);
		s(62, 90, 0, 0, 2);
		s(85, 110, 0, 0, 2);
		s(105, 130, 0, 0, 2);
		s(125, 200, 0, 0, 2);
		s(117, 200, 0, 0, 2);
		s(114, 130, 0, 0, 2);
		flush();
		// Forward-reverse profile; pin and direction bit are both set.
		DIR_IN <= 1'b1;
		wr(`MRP_REG_CTRL, 16'h0017);
		s(35, 40, 0, 0, 0);
		s(50, 50, 0, 0, 0);
		s(62, 0, 0, 1, 0);
		s(58, 0, 0, 1, 0);
		s(85, 0, 0, 1, 1);
		s(102, 110, 0, 0, 1);
		s(97, 110, 0, 0, 1);
		s(195, 200, 0, 0, 1);
		s(230, 5, 0, 2, 1);
		flush();
		// Bypass speed: scaling, floor and direction.
		wr(`MRP_REG_CTRL, 16'h0004);
		s(255, 16'd1000, 1, 0, 1);
		flush();
		wr(`MRP_REG_CTRL, 16'h0014);
		s(20, 16'd156, 1, 0, 0);
		flush();
		DIR_IN <= 1'b0;
		wr(`MRP_REG_CTRL, 16'h0004);
		for (int i = 0; i < 8; i++) begin
			e = $urandom_range(1, 255);
			s(8'(e), 16'((e < 40 ? 40 : e) * 1000 / 255), 1, 0, 0);
		end
		flush();
		// Power and voltage kinds, then zero full-scale speed.
		ekind = MRP_KIND_POWER;
		wr(`MRP_REG_CTRL, 16'h000C);
		s(128, 16'd250, 2, 0, 2);
		flush();
		wr(`MRP_REG_FS_POWER, 16'h0000);
		s(128, 0, 2, 1, 2);
		flush();
		ekind = MRP_KIND_VOLT;
		wr(`MRP_REG_CTRL, 16'h0000);
		s(39, 0, 3, 0, 2);
		s(40, 40, 3, 0, 2);
		s(255, 255, 3, 0, 2);
		s(0, 0, 3, 1, 2);
		flush();
		ekind = MRP_KIND_SPEED;
		wr(`MRP_REG_CTRL, 16'h0004);
		wr(`MRP_REG_FS_SPEED, 16'h0000);
		s(200, 0, 1, 1, 2);
		flush();
		results();
	end
endmodule
